// File: include/swc_map.vh
// register map and constants for the stop/wait bus clock control block
`ifndef SWC_MAP_VH
`define SWC_MAP_VH
// avalon word addresses (byte offset / 4)
`define SWC_ADDR_W        2
`define SWC_ADDR_CTRL0    2'h0
`define SWC_ADDR_CTRL1    2'h1
`define SWC_ADDR_PROTECT  2'h2
`define SWC_ADDR_STATUS   2'h3
// control register 0 fields
`define SWC_C0_OUTSEL_LO  0
`define SWC_C0_OUTSEL_HI  1
`define SWC_C0_WPSTOP     2
`define SWC_C0_DIVSEL0    6
`define SWC_C0_SUBSEL     7
`define SWC_C0_RESET      8'h48
`define SWC_C0_MASK       8'hc7
// control register 1 fields
`define SWC_C1_STOP       0
`define SWC_C1_DIVSEL1_LO 6
`define SWC_C1_DIVSEL1_HI 7
`define SWC_C1_RESET      8'h20
`define SWC_C1_MASK       8'hc1
// protect register
`define SWC_PR_CLKWE      0
// clock output select codes
`define SWC_OUT_PORT      2'h0
`define SWC_OUT_SUB       2'h1
`define SWC_OUT_DIV8      2'h2
`define SWC_OUT_DIV32     2'h3
// division ratio codes
`define SWC_DSEL_1        2'h0
`define SWC_DSEL_2        2'h1
`define SWC_DSEL_4        2'h2
`define SWC_DSEL_16       2'h3
// divider half periods minus one, in main clock cycles
`define SWC_HALF_1        4'h0
`define SWC_HALF_2        4'h0
`define SWC_HALF_4        4'h1
`define SWC_HALF_8        4'h3
`define SWC_HALF_16       4'h7
`define SWC_SUB_HALF32    4'hf
`endif

// File: hw/swc_sync.v
// two flop synchroniser for one level
`timescale 1ns/10ps
`default_nettype none
module swc_sync (
  input  wire clk,
  input  wire nrst,
  input  wire din,
  output reg  dout
);
  reg stage1;
  always @(posedge clk) begin
    if (!nrst) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule
`default_nettype wire

// File: hw/swc_clkdiv.v
// glitch free bus clock enable divider, ratio applied only at a falling transition
`timescale 1ns/10ps
`default_nettype none
`include "swc_map.vh"
module swc_clkdiv (
  input  wire       clk,
  input  wire       nrst,
  input  wire       run,
  input  wire       bypass,
  input  wire [3:0] half,
  output reg        level,
  output wire       rise
);
  reg [3:0] cnt;
  reg [3:0] cur_half;
  reg       cur_bypass;
  wire      wrap = (cnt == cur_half);
  // new ratio latched only at a falling transition, so no short pulses
  assign rise = run & wrap & ~level;
  always @(posedge clk) begin
    if (!nrst) begin
      cnt        <= 4'h0;
      level      <= 1'b0;
      cur_half   <= `SWC_HALF_8;
      cur_bypass <= 1'b0;
    end else if (run) begin
      if (wrap) begin
        cnt   <= 4'h0;
        level <= ~level;
        if (level) begin
          cur_half   <= half;
          cur_bypass <= bypass;
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: hw/swc_top.v
// stop and wait power modes with bus clock divider and pin hold logic
//
// Operation
// - writing one to the stop bit halts oscillators and enters stop mode
// - stop halts bus clock, peripheral, sub, converter clocks; converter, watchdog idle
// - in stop only external pulse timers and external clock serial units run
// - stop ends on reset or an enabled interrupt, then its routine runs
// - reset and stop entry from main clock modes force divide select 0 high
// - stop entry from sub clock modes keeps divide select 0 unchanged
// - stop with external bus holds buses, drives strobes and bus controls high
// - in stop, clock output goes high for sub clock, holds for main divisions
// - wait instruction halts bus clock and watchdog, oscillators keep running
// - with wait peripheral stop bit set, wait also gates peripheral clocks
// - wait ends on reset or interrupt; same bus clock source resumes
// - in wait, bus pins and ports hold, strobes and controls driven high
// - in wait, sub clock output runs; main outputs freeze if stop bit set
// - after reset bus clock is main clock divided by eight
// - division modes give bus clock of main divided by two, four or sixteen
// - two bit divide field applies only while divide select 0 is zero
// - clock register writes take effect only while protect enable bit is one
`timescale 1ns/10ps
`default_nettype none
`include "swc_map.vh"
module swc_top (
  input  wire                   clk,
  input  wire                   nrst,
  // avalon-mm slave
  input  wire [`SWC_ADDR_W-1:0] avs_address,
  input  wire                   avs_read,
  input  wire                   avs_write,
  input  wire [31:0]            avs_writedata,
  input  wire [3:0]             avs_byteenable,
  output reg  [31:0]            avs_readdata,
  output wire                   avs_waitrequest,
  // cpu side events
  input  wire                   wait_exec,
  input  wire                   irq_pending,
  input  wire                   irq_enabled,
  input  wire                   sub_clock_in,
  input  wire                   single_chip,
  input  wire                   ext_count_timer,
  input  wire                   ext_clock_serial,
  // bus pin values in normal operation
  input  wire                   bus_read_strobe_in,
  input  wire                   write_strobe_low_in,
  input  wire                   write_strobe_high_in,
  input  wire                   hold_acknowledge_in,
  input  wire                   addr_latch_in,
  input  wire [7:0]             port_in,
  // clocks and enables produced
  output wire                   bus_clock,
  output wire                   bus_clock_rise,
  output wire                   periph_clock_en,
  output wire                   main_clock_div8,
  output wire                   main_clock_div32,
  output wire                   sub_clock,
  output wire                   sub_clock_div32,
  output wire                   converter_clock_en,
  output wire                   watchdog_en,
  output wire                   timer_ext_en,
  output wire                   serial_ext_en,
  output wire                   osc_enable,
  output wire                   isr_start,
  // pins
  output reg                    bus_read_strobe,
  output reg                    write_strobe_low,
  output reg                    write_strobe_high,
  output reg                    hold_acknowledge,
  output reg                    bus_clock_pin,
  output reg                    addr_latch,
  output reg  [7:0]             port_out,
  output reg                    clock_output_pin,
  output wire                   stop_mode,
  output wire                   wait_mode
);

////////////////////////////////////////////////////////////////////////////////
// mode machine
localparam [2:0] ST_RUN  = 3'b001;
localparam [2:0] ST_WAIT = 3'b010;
localparam [2:0] ST_STOP = 3'b100;

reg  [2:0] state;
reg  [2:0] next_state;
reg  [7:0] ctrl0;
reg  [7:0] ctrl1;
reg        protect_we;
reg        wake_pulse;
wire       sub_sync;
wire       irq_sync;
wire       irqen_sync;

swc_sync u_sync_sub (
  .clk  (clk),
  .nrst (nrst),
  .din  (sub_clock_in),
  .dout (sub_sync)
);

swc_sync u_sync_irq (
  .clk  (clk),
  .nrst (nrst),
  .din  (irq_pending),
  .dout (irq_sync)
);

swc_sync u_sync_irqen (
  .clk  (clk),
  .nrst (nrst),
  .din  (irq_enabled),
  .dout (irqen_sync)
);

wire in_stop = state[2];
wire in_wait = state[1];
assign stop_mode = in_stop;
assign wait_mode = in_wait;

wire [7:0] be_byte = avs_writedata[7:0];
wire       wr_ok   = avs_write & avs_byteenable[0] & protect_we;
wire       stop_req = wr_ok & (avs_address == `SWC_ADDR_CTRL1)
                      & be_byte[`SWC_C1_STOP];

always @* begin
  next_state = state;
  case (state)
    ST_RUN: begin
      if (stop_req)
        next_state = ST_STOP;
      else if (wait_exec)
        next_state = ST_WAIT;
    end
    ST_WAIT: begin
      if (irq_sync)
        next_state = ST_RUN;
    end
    ST_STOP: begin
      if (irq_sync & irqen_sync)
        next_state = ST_RUN;
    end
    default: next_state = ST_RUN;
  endcase
end

// sub clock selected means low-speed or low power mode
wire sub_mode = ctrl0[`SWC_C0_SUBSEL];

always @(posedge clk) begin
  if (!nrst) begin
    state      <= ST_RUN;
    ctrl0      <= `SWC_C0_RESET;
    ctrl1      <= `SWC_C1_RESET;
    protect_we <= 1'b0;
    wake_pulse <= 1'b0;
  end else begin
    state      <= next_state;
    wake_pulse <= (in_stop | in_wait) & (next_state == ST_RUN);
    if (avs_write & avs_byteenable[0] & (avs_address == `SWC_ADDR_PROTECT))
      protect_we <= be_byte[`SWC_PR_CLKWE];
    if (wr_ok & (avs_address == `SWC_ADDR_CTRL0))
      ctrl0 <= be_byte & `SWC_C0_MASK;
    if (stop_req) begin
      ctrl1 <= (be_byte & `SWC_C1_MASK);
      if (!sub_mode)
        ctrl0[`SWC_C0_DIVSEL0] <= 1'b1;
      // sub clock modes leave the bit alone
    end else if (wr_ok & (avs_address == `SWC_ADDR_CTRL1)) begin
      ctrl1 <= be_byte & `SWC_C1_MASK;
    end
    // the stop bit reads back clear once the device has woken
    if (in_stop & (next_state == ST_RUN))
      ctrl1[`SWC_C1_STOP] <= 1'b0;
  end
end
assign isr_start = wake_pulse;

////////////////////////////////////////////////////////////////////////////////
// avalon slave: one wait state on reads, writes take no wait
reg rd_done;
always @(posedge clk) begin
  if (!nrst)
    rd_done <= 1'b0;
  else
    rd_done <= avs_read & ~rd_done;
end
assign avs_waitrequest = avs_read & ~rd_done;

always @(posedge clk) begin
  if (!nrst) begin
    avs_readdata <= 32'h0000_0000;
  end else if (avs_read & ~rd_done) begin
    case (avs_address)
      `SWC_ADDR_CTRL0:   avs_readdata <= {24'h00_0000, ctrl0};
      `SWC_ADDR_CTRL1:   avs_readdata <= {24'h00_0000, ctrl1};
      `SWC_ADDR_PROTECT: avs_readdata <= {31'h0000_0000, protect_we};
      `SWC_ADDR_STATUS:  avs_readdata <= {29'h0000_0000, state};
      default:           avs_readdata <= 32'h0000_0000;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// bus clock divider
function [3:0] half_of;
  input       div0;
  input [1:0] dsel;
  begin
    if (div0)
      half_of = `SWC_HALF_8;
    else begin
      case (dsel)
        `SWC_DSEL_1:  half_of = `SWC_HALF_1;
        `SWC_DSEL_2:  half_of = `SWC_HALF_2;
        `SWC_DSEL_4:  half_of = `SWC_HALF_4;
        `SWC_DSEL_16: half_of = `SWC_HALF_16;
        default:      half_of = `SWC_HALF_8;
      endcase
    end
  end
endfunction

wire [1:0] dsel = {ctrl1[`SWC_C1_DIVSEL1_HI], ctrl1[`SWC_C1_DIVSEL1_LO]};
wire       nodiv = ~ctrl0[`SWC_C0_DIVSEL0] & (dsel == `SWC_DSEL_1);
wire       div_level;
wire       div_rise;
wire       bus_run = state[0];

swc_clkdiv u_div (
  .clk    (clk),
  .nrst   (nrst),
  .run    (bus_run & ~nodiv),
  .bypass (nodiv),
  .half   (half_of(ctrl0[`SWC_C0_DIVSEL0], dsel)),
  .level  (div_level),
  .rise   (div_rise)
);

// sub clock edge after synchroniser
reg sub_prev;
always @(posedge clk) begin
  if (!nrst)
    sub_prev <= 1'b0;
  else
    sub_prev <= sub_sync;
end
wire sub_rise = sub_sync & ~sub_prev;

// source switches happen when both clocks are low, which avoids short pulses
reg src_sub;
always @(posedge clk) begin
  if (!nrst)
    src_sub <= 1'b0;
  else if (~div_level & ~sub_sync)
    src_sub <= sub_mode;
end

// no-division runs the enable every cycle; bus clock then holds the stopped divider level
assign bus_clock_rise = bus_run & (src_sub ? sub_rise : (nodiv ? 1'b1 : div_rise));
assign bus_clock      = src_sub ? (sub_sync & bus_run) : (div_level & bus_run);

////////////////////////////////////////////////////////////////////////////////
// peripheral clocks
reg [4:0] main_cnt;
reg [4:0] sub_cnt;
wire      osc_on  = ~in_stop;
wire      per_run = osc_on & ~(in_wait & ctrl0[`SWC_C0_WPSTOP]);
always @(posedge clk) begin
  if (!nrst) begin
    main_cnt <= 5'h00;
    sub_cnt  <= 5'h00;
  end else begin
    if (per_run)
      main_cnt <= main_cnt + 5'h01;
    if (osc_on & sub_rise)
      sub_cnt <= sub_cnt + 5'h01; // sub div32 is not gated by the wait bit
  end
end
assign main_clock_div8    = main_cnt[2];
assign main_clock_div32   = main_cnt[4];
assign sub_clock          = sub_sync & osc_on;
assign sub_clock_div32    = sub_cnt[4];
assign periph_clock_en    = per_run;
assign converter_clock_en = per_run;
assign watchdog_en        = state[0];
assign osc_enable         = osc_on;
assign timer_ext_en       = ext_count_timer | ~in_stop;
assign serial_ext_en      = ext_clock_serial | ~in_stop;

////////////////////////////////////////////////////////////////////////////////
// pins
wire       idle    = in_stop | in_wait;
wire [1:0] out_sel = {ctrl0[`SWC_C0_OUTSEL_HI], ctrl0[`SWC_C0_OUTSEL_LO]};
reg        next_clock_output_pin;
always @* begin
  case (out_sel)
    `SWC_OUT_SUB: next_clock_output_pin = in_stop ? 1'b1 : sub_sync;
    `SWC_OUT_DIV8: next_clock_output_pin = (in_stop | ~per_run) ? clock_output_pin
                                 : main_clock_div8;
    `SWC_OUT_DIV32: next_clock_output_pin = (in_stop | ~per_run) ? clock_output_pin
                                  : main_clock_div32;
    default: next_clock_output_pin = idle ? clock_output_pin : port_in[7];
  endcase
end

always @(posedge clk) begin
  if (!nrst) begin
    bus_read_strobe   <= 1'b1;
    write_strobe_low  <= 1'b1;
    write_strobe_high <= 1'b1;
    hold_acknowledge  <= 1'b1;
    bus_clock_pin     <= 1'b1;
    addr_latch        <= 1'b1;
    port_out          <= 8'h00;
    clock_output_pin  <= 1'b0;
  end else begin
    if (idle) begin
      bus_read_strobe   <= 1'b1;
      write_strobe_low  <= 1'b1;
      write_strobe_high <= 1'b1;
      hold_acknowledge  <= 1'b1;
      bus_clock_pin     <= 1'b1;
      addr_latch        <= 1'b1;
      // ports and address lines simply hold
    end else begin
      bus_read_strobe   <= bus_read_strobe_in;
      write_strobe_low  <= write_strobe_low_in;
      write_strobe_high <= write_strobe_high_in;
      hold_acknowledge  <= hold_acknowledge_in;
      bus_clock_pin     <= bus_clock;
      addr_latch        <= addr_latch_in;
      port_out          <= port_in;
    end
    if (single_chip)
      clock_output_pin <= next_clock_output_pin;
  end
end

endmodule
`default_nettype wire

// File: test/swc_top_sva.sv
// assertion checker for the stop/wait bus clock control block
`timescale 1ns/10ps
`default_nettype none
module swc_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [1:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        wait_exec,
  input wire logic        irq_pending,
  input wire logic        irq_enabled,
  input wire logic        bus_clock_rise,
  input wire logic        periph_clock_en,
  input wire logic        converter_clock_en,
  input wire logic        watchdog_en,
  input wire logic        osc_enable,
  input wire logic        isr_start,
  input wire logic        bus_read_strobe,
  input wire logic        write_strobe_low,
  input wire logic        hold_acknowledge,
  input wire logic        addr_latch,
  input wire logic [7:0]  port_out,
  input wire logic        stop_mode,
  input wire logic        wait_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  a_stop_entry: assert property ($rose(stop_mode) |-> $past(avs_write && avs_writedata[0]
    && avs_address == 2'h1 && avs_byteenable[0])) else $error("stop without stop write");
  a_stop_clocks: assert property (stop_mode |-> !(osc_enable || bus_clock_rise
    || periph_clock_en || converter_clock_en || watchdog_en)) else $error("clock runs in stop");
  a_wait_entry: assert property (wait_exec && !stop_mode && !wait_mode |=> wait_mode)
    else $error("wait not entered");
  a_wait_clocks: assert property (wait_mode |-> osc_enable && !watchdog_en
    && !bus_clock_rise) else $error("wrong clocks in wait");
  a_pins_hold: assert property ((stop_mode || wait_mode)[*3] |-> bus_read_strobe
    && write_strobe_low && hold_acknowledge && addr_latch && $stable(port_out))
    else $error("pins not held in low power mode");
  a_stop_leave: assert property (stop_mode && irq_pending && irq_enabled
    |-> ##[1:5] !stop_mode) else $error("stop not left on enabled interrupt");
  a_wait_leave: assert property (wait_mode && irq_pending |-> ##[1:5] !wait_mode)
    else $error("wait not left on interrupt");
  a_isr_wake: assert property ($fell(stop_mode) |-> ##[0:2] isr_start)
    else $error("no service start after stop wake");
  c_stop: cover property ($rose(stop_mode));
  c_wait: cover property ($rose(wait_mode));
  c_isr: cover property (isr_start);
endmodule
bind swc_top swc_chk u_chk (
  .clk (clk), .nrst (nrst), .avs_address (avs_address), .avs_write (avs_write),
  .avs_writedata (avs_writedata), .avs_byteenable (avs_byteenable), .wait_exec (wait_exec),
  .irq_pending (irq_pending), .irq_enabled (irq_enabled), .bus_clock_rise (bus_clock_rise),
  .periph_clock_en (periph_clock_en), .converter_clock_en (converter_clock_en),
  .watchdog_en (watchdog_en), .osc_enable (osc_enable), .isr_start (isr_start),
  .bus_read_strobe (bus_read_strobe), .write_strobe_low (write_strobe_low),
  .hold_acknowledge (hold_acknowledge), .addr_latch (addr_latch), .port_out (port_out),
  .stop_mode (stop_mode), .wait_mode (wait_mode)
);
`default_nettype wire

// File: test/test_stop_wait_bus_clock_control.sv
// self-checking bench for the stop/wait bus clock control block
`timescale 1ns/10ps
`default_nettype none
module test_stop_wait_bus_clock_control;
  logic        clk, nrst, avs_read, avs_write, avs_waitrequest, wait_exec, irq_pending;
  logic        irq_enabled, sub_clock_in, single_chip, ext_count_timer, ext_clock_serial;
  logic        bus_read_strobe_in, write_strobe_low_in, write_strobe_high_in;
  logic        hold_acknowledge_in, addr_latch_in, bus_clock, bus_clock_rise, periph_clock_en;
  logic        main_clock_div8, main_clock_div32, sub_clock, sub_clock_div32, converter_clock_en;
  logic        watchdog_en, timer_ext_en, serial_ext_en, osc_enable, isr_start, bus_read_strobe;
  logic        write_strobe_low, write_strobe_high, hold_acknowledge, bus_clock_pin, addr_latch;
  logic        clock_output_pin, stop_mode, wait_mode, prev_div8;
  logic [1:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [7:0]  port_in, port_out, hold_v, exp_q[$];
  logic [31:0] avs_writedata, avs_readdata;
  integer      seed = 32'h2620fd43;
  int          bad_count, check_count, n;
  swc_top DUT (
    .clk (clk), .nrst (nrst), .avs_address (avs_address), .avs_read (avs_read),
    .avs_write (avs_write), .avs_writedata (avs_writedata), .avs_byteenable (avs_byteenable),
    .avs_readdata (avs_readdata), .avs_waitrequest (avs_waitrequest), .wait_exec (wait_exec),
    .irq_pending (irq_pending), .irq_enabled (irq_enabled), .sub_clock_in (sub_clock_in),
    .single_chip (single_chip), .ext_count_timer (ext_count_timer),
    .ext_clock_serial (ext_clock_serial), .bus_read_strobe_in (bus_read_strobe_in),
    .write_strobe_low_in (write_strobe_low_in), .write_strobe_high_in (write_strobe_high_in),
    .hold_acknowledge_in (hold_acknowledge_in), .addr_latch_in (addr_latch_in),
    .port_in (port_in), .bus_clock (bus_clock), .bus_clock_rise (bus_clock_rise),
    .periph_clock_en (periph_clock_en), .main_clock_div8 (main_clock_div8),
    .main_clock_div32 (main_clock_div32), .sub_clock (sub_clock),
    .sub_clock_div32 (sub_clock_div32), .converter_clock_en (converter_clock_en),
    .watchdog_en (watchdog_en), .timer_ext_en (timer_ext_en), .serial_ext_en (serial_ext_en),
    .osc_enable (osc_enable), .isr_start (isr_start), .bus_read_strobe (bus_read_strobe),
    .write_strobe_low (write_strobe_low), .write_strobe_high (write_strobe_high),
    .hold_acknowledge (hold_acknowledge), .bus_clock_pin (bus_clock_pin),
    .addr_latch (addr_latch), .port_out (port_out), .clock_output_pin (clock_output_pin),
    .stop_mode (stop_mode), .wait_mode (wait_mode)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // pins and sub clock change every cycle so any missing hold shows up
  always @(posedge clk) begin
    sub_clock_in <= $random(seed);
    port_in <= $random(seed);
    {bus_read_strobe_in, write_strobe_low_in, write_strobe_high_in} <= $random(seed);
    {hold_acknowledge_in, addr_latch_in} <= $random(seed);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      chk(avs_readdata, {24'h0, exp_q.pop_front()});
    end
  end
  // spacing of bus clock rises, after two periods so a ratio change has landed
  task automatic span(input int p);
    int c;
    repeat (2) begin
      do @(posedge clk); while (bus_clock_rise !== 1'b1);
    end
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (bus_clock_rise !== 1'b1 && c < 64);
    chk(c, p);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wake(input logic en);
    irq_enabled <= en;
    irq_pending <= 1'b1;
    n = 0;
    repeat (8) @(posedge clk) if (isr_start === 1'b1) n++;
    chk({stop_mode, wait_mode}, 2'b00);
    irq_pending <= 1'b0;
    irq_enabled <= 1'b0;
  endtask
  initial begin
    #1000000;
    bad_count++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, avs_read, avs_write, wait_exec, irq_pending, irq_enabled, sub_clock_in} = 7'h0;
    {single_chip, ext_count_timer, ext_clock_serial} = 3'b110;
    {bus_read_strobe_in, write_strobe_low_in, write_strobe_high_in} = 3'h0;
    {hold_acknowledge_in, addr_latch_in, port_in} = 10'h0;
    avs_address = 2'h0;
    avs_byteenable = 4'h1;
    avs_writedata = 32'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(2'h0, 8'h48);
    rd(2'h1, 8'h20);
    rd(2'h3, 8'h01);
    span(8);
    wr(2'h1, 8'h41);
    rd(2'h1, 8'h20);
    wr(2'h2, 8'h01);
    avs_byteenable <= 4'he;
    wr(2'h1, 8'h41);
    avs_byteenable <= 4'h1;
    rd(2'h1, 8'h20);
    $display("test reset and protect done");
    wr(2'h0, 8'h00);
    for (int i = 1; i < 4; i++) begin
      wr(2'h1, {i[1:0], 6'h00});
      span(i == 3 ? 16 : 2 * i);
    end
    wr(2'h0, 8'h40);
    span(8);
    $display("test ratios done");
    wr(2'h0, 8'h01);
    wr(2'h1, 8'hc1);
    repeat (3) @(posedge clk);
    hold_v = port_out;
    chk({stop_mode, clock_output_pin}, 2'b11);
    chk({osc_enable, sub_clock, converter_clock_en, watchdog_en}, 4'h0);
    chk({timer_ext_en, serial_ext_en}, 2'b10);
    chk({bus_read_strobe, write_strobe_low, write_strobe_high}, 3'h7);
    chk({hold_acknowledge, bus_clock_pin, addr_latch}, 3'h7);
    irq_pending <= 1'b1;
    repeat (10) @(posedge clk);
    chk({stop_mode, port_out}, {1'b1, hold_v});
    wake(1'b1);
    chk(n, 1);
    rd(2'h0, 8'h41);
    rd(2'h1, 8'hc0);
    wr(2'h0, 8'h82);
    wr(2'h1, 8'h01);
    repeat (3) @(posedge clk);
    n = clock_output_pin;
    repeat (12) @(posedge clk);
    chk(clock_output_pin, n[0]);
    wake(1'b1);
    rd(2'h0, 8'h82);
    $display("test stop done");
    wr(2'h0, 8'h06);
    wr(2'h1, 8'h40);
    // leaving the sub clock waits for both clocks low, so give the switch time
    repeat (64) @(posedge clk);
    span(2);
    wait_exec <= 1'b1;
    @(posedge clk);
    wait_exec <= 1'b0;
    repeat (3) @(posedge clk);
    hold_v = port_out;
    n = clock_output_pin;
    chk({wait_mode, periph_clock_en, osc_enable}, 3'b101);
    repeat (20) @(posedge clk);
    chk({port_out, clock_output_pin}, {hold_v, n[0]});
    wake(1'b0);
    span(2);
    wr(2'h0, 8'h02);
    wait_exec <= 1'b1;
    @(posedge clk);
    wait_exec <= 1'b0;
    repeat (3) @(posedge clk);
    n = 0;
    // the pin is registered, so it follows the divided clock one cycle late
    prev_div8 = main_clock_div8;
    repeat (40) begin
      @(posedge clk);
      if (clock_output_pin !== prev_div8) n++;
      prev_div8 = main_clock_div8;
    end
    chk({wait_mode, periph_clock_en}, 2'b11);
    chk(n, 0);
    wake(1'b0);
    $display("test wait done");
    test_done();
  end
endmodule
`default_nettype wire
